// *** verilog/nvmac_defines.svh ***
// How it works
// - flash rows hold 32 words of 14 bits; row erase is the smallest erase
// - row data is staged in hidden 14-bit latches loaded through the data pair
// - any subset of a row may be programmed; unloaded latches are skipped
// - only row erase and row write exist; no whole-array erase
// - the eeprom region has 256 locations of 8 bits
// - eeprom writes act on one location at a time
// - indirect reads take one cycle, stall the cpu once, return one word
// - indirect write attempts still read but never write nonvolatile memory
// - register path writes flash, user id, eeprom; id, revision, config are read only
// - code protection blocks every register path read, write and erase
// - read trigger stalls the cpu and fills the data pair next cycle
// - data pair holds until another read or a software write
// - hardware clears the read trigger when the read completes
// - erase, latch load, row write and eeprom write need a fresh unlock
// - the cpu stalls until a flash write or erase finishes
// - no filler cycles are needed after the write trigger
// - erase drives bits to one, flash and id programming only drives bits to zero; eeprom writes replace the byte
// - eeprom write completion clears write trigger and sets the completion flag
`ifndef NVMAC_DEFINES_SVH
`define NVMAC_DEFINES_SVH
`define NVMAC_OFS_CTRL      3'h0
`define NVMAC_OFS_KEY       3'h1
`define NVMAC_OFS_ADRL      3'h2
`define NVMAC_OFS_ADRH      3'h3
`define NVMAC_OFS_DATL      3'h4
`define NVMAC_OFS_DATH      3'h5
`define NVMAC_CTRL_RD       0
`define NVMAC_CTRL_WR       1
`define NVMAC_CTRL_WREN     2
`define NVMAC_CTRL_FREE     3
`define NVMAC_CTRL_LWLO     4
`define NVMAC_CTRL_SPACE    6
`define NVMAC_CTRL_FLAG     7
`define NVMAC_KEY1          8'h55
`define NVMAC_KEY2          8'hAA
`define NVMAC_EE_BASE       15'h7000
`define NVMAC_EE_LAST       15'h70FF
`define NVMAC_FLASH_LAST    15'h07FF
`define NVMAC_UID_LAST      15'h0003
`define NVMAC_ROW_WORDS     32
`define NVMAC_LAST_IDX      5'h1F
`define NVMAC_WORD_W        14
`define NVMAC_IND_FLASH_BIT 15
`endif

// *** verilog/nvmac_pkg.sv ***
`include "nvmac_defines.svh"
package nvmac_pkg;
  typedef logic [`NVMAC_WORD_W-1:0] nvmac_word_t;
  typedef logic [14:0]              nvmac_addr_t;
  typedef logic [4:0]               nvmac_idx_t;
  typedef enum {
    NVMAC_IDLE,
    NVMAC_READ,
    NVMAC_EREQ,
    NVMAC_EWAIT,
    NVMAC_PROG,
    NVMAC_PWAIT,
    NVMAC_EEREQ,
    NVMAC_EEWAIT
  } nvmac_state_e;
  typedef enum {
    NVMAC_UNL_IDLE,
    NVMAC_UNL_KEY1,
    NVMAC_UNL_ARMED
  } nvmac_unl_e;
endpackage

// *** verilog/nvmac_if.sv ***
`timescale 1ns/1ps
interface nvmac_if;
  logic                 key_wr;
  logic [7:0]           key_val;
  logic                 other_acc;
  logic                 consume;
  logic                 armed;
  logic                 ld;
  nvmac_pkg::nvmac_idx_t  ld_idx;
  nvmac_pkg::nvmac_word_t ld_data;
  logic                 clr;
  nvmac_pkg::nvmac_idx_t  rd_idx;
  nvmac_pkg::nvmac_word_t rd_data;
  logic                 rd_loaded;
  modport unl (input key_wr, key_val, other_acc, consume, output armed);
  modport lat (input ld, ld_idx, ld_data, clr, rd_idx, output rd_data, rd_loaded);
  modport ctl (output key_wr, key_val, other_acc, consume, ld, ld_idx, ld_data, clr, rd_idx,
               input armed, rd_data, rd_loaded);
endinterface

// *** verilog/nvmac_unlock.sv ***
`timescale 1ns/1ps
`include "nvmac_defines.svh"
module nvmac_unlock (
  input  wire logic clk,
  input  wire logic nrst,
  nvmac_if.unl      bus
);
  nvmac_pkg::nvmac_unl_e st_q;
  nvmac_pkg::nvmac_unl_e st_d;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      nvmac_pkg::NVMAC_UNL_IDLE:
        if (bus.key_wr && bus.key_val == `NVMAC_KEY1)
          st_d = nvmac_pkg::NVMAC_UNL_KEY1;
      nvmac_pkg::NVMAC_UNL_KEY1:
        if (bus.key_wr && bus.key_val == `NVMAC_KEY2)
          st_d = nvmac_pkg::NVMAC_UNL_ARMED;
        else if (bus.key_wr || bus.other_acc || bus.consume)
          st_d = nvmac_pkg::NVMAC_UNL_IDLE;
      nvmac_pkg::NVMAC_UNL_ARMED:
        if (bus.consume || bus.key_wr || bus.other_acc)
          st_d = nvmac_pkg::NVMAC_UNL_IDLE;
      default:
        st_d = nvmac_pkg::NVMAC_UNL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_q <= nvmac_pkg::NVMAC_UNL_IDLE;
    else
      st_q <= st_d;
  end

  assign bus.armed = (st_q == nvmac_pkg::NVMAC_UNL_ARMED);

  property p_arm_order;
    @(posedge clk) disable iff (!nrst)
    $rose(bus.armed) |-> $past(bus.key_wr && bus.key_val == `NVMAC_KEY2);
  endproperty
  a_arm_order: assert property (p_arm_order) else $error("unlock armed without second key");

  property p_drop;
    @(posedge clk) disable iff (!nrst)
    (bus.other_acc || bus.consume) && !bus.key_wr |=> !bus.armed;
  endproperty
  a_drop: assert property (p_drop) else $error("unlock survived another access");
endmodule // nvmac_unlock

// *** verilog/nvmac_latch.sv ***
`timescale 1ns/1ps
`include "nvmac_defines.svh"
module nvmac_latch (
  input  wire logic clk,
  input  wire logic nrst,
  nvmac_if.lat      bus
);
  nvmac_pkg::nvmac_word_t word_q   [`NVMAC_ROW_WORDS];
  logic                   loaded_q [`NVMAC_ROW_WORDS];

  genvar i;
  generate
    for (i = 0; i < `NVMAC_ROW_WORDS; i++)
    begin : g_ent
      nvmac_pkg::nvmac_word_t word_d;
      logic                   loaded_d;
      always_comb
      begin
        word_d   = word_q[i];
        loaded_d = loaded_q[i];
        if (bus.clr)
          loaded_d = 1'b0;
        if (bus.ld && bus.ld_idx == 5'(i))
        begin
          word_d   = bus.ld_data;
          loaded_d = 1'b1;
        end
      end
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          word_q[i]   <= 14'h3FFF;
          loaded_q[i] <= 1'b0;
        end
        else
        begin
          word_q[i]   <= word_d;
          loaded_q[i] <= loaded_d;
        end
      end
    end
  endgenerate

  assign bus.rd_data   = word_q[bus.rd_idx];
  assign bus.rd_loaded = loaded_q[bus.rd_idx];

  property p_clear;
    @(posedge clk) disable iff (!nrst)
    bus.clr && !bus.ld |=> !loaded_q[$past(bus.rd_idx)];
  endproperty
  a_clear: assert property (p_clear) else $error("latch still loaded after clear");
endmodule // nvmac_latch

// *** verilog/nvm_access_controller.sv ***
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "nvmac_defines.svh"
module nvm_access_controller (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [2:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic        IND_REQ,
  input  wire logic        IND_WE,
  input  wire logic [15:0] IND_ADDR,
  output logic      [13:0] IND_RDATA,
  output logic             IND_VALID,
  input  wire logic        CODE_PROT,
  output logic             CPU_STALL,
  output logic      [14:0] MEM_ADDR,
  output logic             MEM_SPACE,
  output logic             MEM_RD,
  input  wire logic [13:0] MEM_RDATA,
  output logic             MEM_ERASE,
  output logic             MEM_PROG,
  output logic      [13:0] MEM_WDATA,
  input  wire logic        MEM_DONE
);
  nvmac_if u_if ();

  nvmac_pkg::nvmac_state_e st_q;
  nvmac_pkg::nvmac_state_e st_d;
  logic                    rd_q;
  logic                    rd_d;
  logic                    wr_q;
  logic                    wr_d;
  logic                    wren_q;
  logic                    wren_d;
  logic                    free_q;
  logic                    free_d;
  logic                    lwlo_q;
  logic                    lwlo_d;
  logic                    space_q;
  logic                    space_d;
  logic                    flag_q;
  logic                    flag_d;
  logic [7:0]              adrl_q;
  logic [7:0]              adrl_d;
  logic [6:0]              adrh_q;
  logic [6:0]              adrh_d;
  logic [7:0]              datl_q;
  logic [7:0]              datl_d;
  logic [5:0]              dath_q;
  logic [5:0]              dath_d;
  nvmac_pkg::nvmac_idx_t   idx_q;
  nvmac_pkg::nvmac_idx_t   idx_d;
  logic [7:0]              rdata_q;
  logic [7:0]              rdata_d;
  logic [13:0]             ind_q;
  logic [13:0]             ind_d;
  logic                    ind_v_q;
  logic                    ind_v_d;
  nvmac_pkg::nvmac_addr_t  addr;
  logic                    ctrl_wr;
  logic                    go_ok;
  logic                    is_ee;
  logic                    is_flash;
  logic                    is_uid;
  logic                    wr_allowed;
  logic                    done_ev;
  logic                    row_end;

  nvmac_unlock u_unlock (
    .clk  (CLK),
    .nrst (NRST),
    .bus  (u_if.unl)
  );

  nvmac_latch u_latch (
    .clk  (CLK),
    .nrst (NRST),
    .bus  (u_if.lat)
  );

  assign addr       = {adrh_q, adrl_q};
  assign ctrl_wr    = WR && ADDR == `NVMAC_OFS_CTRL;
  assign is_ee      = WDATA[`NVMAC_CTRL_SPACE] && addr >= `NVMAC_EE_BASE && addr <= `NVMAC_EE_LAST;
  assign is_flash   = !WDATA[`NVMAC_CTRL_SPACE] && addr <= `NVMAC_FLASH_LAST;
  assign is_uid     = WDATA[`NVMAC_CTRL_SPACE] && addr <= `NVMAC_UID_LAST;
  assign wr_allowed = is_ee || is_flash || is_uid;
  assign go_ok      = u_if.armed && WDATA[`NVMAC_CTRL_WREN] && !CODE_PROT && wr_allowed;
  assign row_end    = idx_q == `NVMAC_LAST_IDX;

  always_comb
  begin
    st_d      = st_q;
    rd_d      = rd_q;
    wr_d      = wr_q;
    wren_d    = wren_q;
    free_d    = free_q;
    lwlo_d    = lwlo_q;
    space_d   = space_q;
    flag_d    = flag_q;
    adrl_d    = adrl_q;
    adrh_d    = adrh_q;
    datl_d    = datl_q;
    dath_d    = dath_q;
    idx_d     = idx_q;
    rdata_d   = 8'h00;
    ind_d     = ind_q;
    ind_v_d   = 1'b0;
    done_ev   = 1'b0;
    MEM_ADDR  = addr;
    MEM_SPACE = space_q;
    MEM_RD    = 1'b0;
    MEM_ERASE = 1'b0;
    MEM_PROG  = 1'b0;
    MEM_WDATA = {dath_q, datl_q};
    CPU_STALL = 1'b0;
    u_if.key_wr    = WR && ADDR == `NVMAC_OFS_KEY;
    u_if.key_val   = WDATA;
    u_if.other_acc = RD || (WR && ADDR != `NVMAC_OFS_KEY && !ctrl_wr) || IND_REQ
                     || (ctrl_wr && !WDATA[`NVMAC_CTRL_WR]);
    u_if.consume   = ctrl_wr && WDATA[`NVMAC_CTRL_WR];
    u_if.ld        = 1'b0;
    u_if.ld_idx    = adrl_q[4:0];
    u_if.ld_data   = {dath_q, datl_q};
    u_if.clr       = 1'b0;
    u_if.rd_idx    = idx_q;
    if (RD)
    begin
      case (ADDR)
        `NVMAC_OFS_CTRL: rdata_d = {flag_q, space_q, 1'b0, lwlo_q, free_q, wren_q, wr_q, rd_q};
        `NVMAC_OFS_ADRL: rdata_d = adrl_q;
        `NVMAC_OFS_ADRH: rdata_d = {1'b0, adrh_q};
        `NVMAC_OFS_DATL: rdata_d = datl_q;
        `NVMAC_OFS_DATH: rdata_d = {2'b00, dath_q};
        default:         rdata_d = 8'h00;
      endcase
    end
    if (WR)
    begin
      case (ADDR)
        `NVMAC_OFS_CTRL:
        begin
          wren_d  = WDATA[`NVMAC_CTRL_WREN];
          free_d  = WDATA[`NVMAC_CTRL_FREE];
          lwlo_d  = WDATA[`NVMAC_CTRL_LWLO];
          space_d = WDATA[`NVMAC_CTRL_SPACE];
          if (!WDATA[`NVMAC_CTRL_FLAG])
            flag_d = 1'b0;
        end
        `NVMAC_OFS_ADRL: adrl_d = WDATA;
        `NVMAC_OFS_ADRH: adrh_d = WDATA[6:0];
        `NVMAC_OFS_DATL: datl_d = WDATA;
        `NVMAC_OFS_DATH: dath_d = WDATA[5:0];
        default: ;
      endcase
    end
    // indirect read: write attempts on this path still read and stall but never write or raise IND_VALID
    if (IND_REQ && st_q != nvmac_pkg::NVMAC_READ)
    begin
      MEM_RD    = 1'b1;
      MEM_SPACE = !IND_ADDR[`NVMAC_IND_FLASH_BIT];
      MEM_ADDR  = IND_ADDR[`NVMAC_IND_FLASH_BIT] ? IND_ADDR[14:0] : (`NVMAC_EE_BASE | {7'h00, IND_ADDR[7:0]});
      CPU_STALL = 1'b1;
      ind_d     = MEM_RDATA;
      ind_v_d   = !IND_WE;
    end
    case (st_q)
      nvmac_pkg::NVMAC_IDLE:
        if (ctrl_wr && WDATA[`NVMAC_CTRL_RD])
        begin
          if (!CODE_PROT)
          begin
            rd_d = 1'b1;
            st_d = nvmac_pkg::NVMAC_READ;
          end
        end
        else if (ctrl_wr && WDATA[`NVMAC_CTRL_WR] && go_ok)
        begin
          idx_d = 5'h00;
          if (is_ee)
          begin
            wr_d = 1'b1;
            st_d = nvmac_pkg::NVMAC_EEREQ;
          end
          else if (WDATA[`NVMAC_CTRL_FREE])
          begin
            wr_d = 1'b1;
            st_d = nvmac_pkg::NVMAC_EREQ;
          end
          else
          begin
            u_if.ld = 1'b1;
            if (!WDATA[`NVMAC_CTRL_LWLO])
            begin
              wr_d = 1'b1;
              st_d = nvmac_pkg::NVMAC_PROG;
            end
          end
        end
      nvmac_pkg::NVMAC_READ:
      begin
        MEM_RD    = 1'b1;
        CPU_STALL = 1'b1;
        datl_d    = MEM_RDATA[7:0];
        dath_d    = MEM_RDATA[13:8];
        rd_d      = 1'b0;
        st_d      = nvmac_pkg::NVMAC_IDLE;
      end
      nvmac_pkg::NVMAC_EREQ:
      begin
        MEM_ERASE = 1'b1;
        MEM_ADDR  = {addr[14:5], 5'h00};
        CPU_STALL = 1'b1;
        st_d      = nvmac_pkg::NVMAC_EWAIT;
      end
      nvmac_pkg::NVMAC_EWAIT:
      begin
        CPU_STALL = !MEM_DONE;
        if (MEM_DONE)
        begin
          done_ev = 1'b1;
          st_d    = nvmac_pkg::NVMAC_IDLE;
        end
      end
      nvmac_pkg::NVMAC_PROG, nvmac_pkg::NVMAC_PWAIT:
      begin
        CPU_STALL = 1'b1;
        MEM_ADDR  = {addr[14:5], idx_q};
        MEM_WDATA = u_if.rd_data;
        if (st_q == nvmac_pkg::NVMAC_PROG && u_if.rd_loaded)
        begin
          MEM_PROG = 1'b1;
          st_d     = nvmac_pkg::NVMAC_PWAIT;
        end
        else if (st_q == nvmac_pkg::NVMAC_PROG || MEM_DONE)
        begin
          idx_d = idx_q + 5'h01;
          st_d  = nvmac_pkg::NVMAC_PROG;
          if (row_end)
          begin
            CPU_STALL = 1'b0;
            u_if.clr  = 1'b1;
            done_ev   = 1'b1;
            st_d      = nvmac_pkg::NVMAC_IDLE;
          end
        end
      end
      nvmac_pkg::NVMAC_EEREQ:
      begin
        MEM_PROG  = 1'b1;
        MEM_SPACE = 1'b1;
        MEM_ADDR  = addr;
        MEM_WDATA = {6'h00, datl_q};
        st_d      = nvmac_pkg::NVMAC_EEWAIT;
      end
      nvmac_pkg::NVMAC_EEWAIT:
        if (MEM_DONE)
        begin
          done_ev = 1'b1;
          st_d    = nvmac_pkg::NVMAC_IDLE;
        end
      default:
        st_d = nvmac_pkg::NVMAC_IDLE;
    endcase
    if (done_ev)
    begin
      wr_d   = 1'b0;
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q    <= nvmac_pkg::NVMAC_IDLE;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      wren_q  <= 1'b0;
      free_q  <= 1'b0;
      lwlo_q  <= 1'b0;
      space_q <= 1'b0;
      flag_q  <= 1'b0;
      adrl_q  <= 8'h00;
      adrh_q  <= 7'h00;
      datl_q  <= 8'h00;
      dath_q  <= 6'h00;
      idx_q   <= 5'h00;
      rdata_q <= 8'h00;
      ind_q   <= 14'h0000;
      ind_v_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      wren_q  <= wren_d;
      free_q  <= free_d;
      lwlo_q  <= lwlo_d;
      space_q <= space_d;
      flag_q  <= flag_d;
      adrl_q  <= adrl_d;
      adrh_q  <= adrh_d;
      datl_q  <= datl_d;
      dath_q  <= dath_d;
      idx_q   <= idx_d;
      rdata_q <= rdata_d;
      ind_q   <= ind_d;
      ind_v_q <= ind_v_d;
    end
  end

  assign RDATA     = rdata_q;
  assign IND_RDATA = ind_q;
  assign IND_VALID = ind_v_q;

  property p_reg_read;
    @(posedge CLK) disable iff (!NRST)
    st_q == nvmac_pkg::NVMAC_READ |-> CPU_STALL ##1 ({dath_q, datl_q} == $past(MEM_RDATA) && !rd_q);
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("register read data or trigger wrong");

  property p_ind_read;
    @(posedge CLK) disable iff (!NRST)
    IND_REQ && !IND_WE && st_q != nvmac_pkg::NVMAC_READ |-> MEM_RD && CPU_STALL
      ##1 IND_VALID && IND_RDATA == $past(MEM_RDATA) ##1 !IND_VALID || $past(IND_REQ);
  endproperty
  a_ind_read: assert property (p_ind_read) else $error("indirect read not one cycle");

  property p_hold;
    @(posedge CLK) disable iff (!NRST)
    st_q != nvmac_pkg::NVMAC_READ && !(WR && (ADDR == `NVMAC_OFS_DATL || ADDR == `NVMAC_OFS_DATH))
      |=> $stable({dath_q, datl_q});
  endproperty
  a_hold: assert property (p_hold) else $error("data pair changed without cause");

  property p_prot;
    @(posedge CLK) disable iff (!NRST)
    CODE_PROT && st_q == nvmac_pkg::NVMAC_IDLE |=> st_q == nvmac_pkg::NVMAC_IDLE;
  endproperty
  a_prot: assert property (p_prot) else $error("operation started under code protection");

  property p_unlock;
    @(posedge CLK) disable iff (!NRST)
    st_q == nvmac_pkg::NVMAC_IDLE && st_d != nvmac_pkg::NVMAC_IDLE && st_d != nvmac_pkg::NVMAC_READ
      |-> u_if.armed;
  endproperty
  a_unlock: assert property (p_unlock) else $error("write started without unlock");

  property p_stall;
    @(posedge CLK) disable iff (!NRST)
    st_q == nvmac_pkg::NVMAC_EREQ |-> CPU_STALL [*2];
  endproperty
  a_stall: assert property (p_stall) else $error("cpu not stalled for erase");

  property p_ee_done;
    @(posedge CLK) disable iff (!NRST)
    st_q == nvmac_pkg::NVMAC_EEWAIT && MEM_DONE |=> !wr_q && flag_q && st_q == nvmac_pkg::NVMAC_IDLE;
  endproperty
  a_ee_done: assert property (p_ee_done) else $error("eeprom completion not flagged");

  property p_ind_we;
    @(posedge CLK) disable iff (!NRST)
    IND_REQ && IND_WE |=> !IND_VALID;
  endproperty
  a_ind_we: assert property (p_ind_we) else $error("indirect write produced an access");
endmodule // nvm_access_controller

// *** test/nvmac_mem_model.sv ***
`timescale 1ns/1ps
module nvmac_mem_model #(
  parameter int DONE_LAT = 4
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [14:0] MEM_ADDR,
  input  wire logic        MEM_SPACE,
  input  wire logic        MEM_RD,
  output logic      [13:0] MEM_RDATA,
  input  wire logic        MEM_ERASE,
  input  wire logic        MEM_PROG,
  input  wire logic [13:0] MEM_WDATA,
  output logic             MEM_DONE
);
  logic [13:0] flash [0:2047];
  logic [13:0] uid   [0:3];
  logic [7:0]  ee    [0:255];
  logic [13:0] rd_val;
  logic [7:0]  cnt;
  logic        tog;
  int          prog_count;
  initial
  begin
    for (int i = 0; i < 2048; i++)
      flash[i] = 14'(i) ^ 14'h1555;
    for (int i = 0; i < 4; i++)
      uid[i] = 14'h0A00 + 14'(i);
    for (int i = 0; i < 256; i++)
      ee[i] = 8'(i) ^ 8'h3C;
  end
  always_comb
  begin
    rd_val = 14'h0000;
    if (!MEM_SPACE && MEM_ADDR <= 15'h07FF)
      rd_val = flash[MEM_ADDR[10:0]];
    else if (MEM_SPACE && MEM_ADDR <= 15'h0003)
      rd_val = uid[MEM_ADDR[1:0]];
    else if (MEM_SPACE && MEM_ADDR[14:8] == 7'h70)
      rd_val = {6'h00, ee[MEM_ADDR[7:0]]};
  end
  // read bus not driven: pattern changes every cycle
  assign MEM_RDATA = MEM_RD ? rd_val : {7{tog, ~tog}};
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cnt <= 8'h00;
      MEM_DONE <= 1'b0;
      tog <= 1'b0;
      prog_count <= 0;
    end
    else
    begin
      tog <= ~tog;
      MEM_DONE <= (cnt == 8'h01);
      if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
      if (MEM_ERASE)
      begin
        // only a whole row is ever cleared, to ones
        for (int j = 0; j < 32; j++)
          if (!MEM_SPACE)
            flash[{MEM_ADDR[10:5], 5'(j)}] <= 14'h3FFF;
          else if (j < 4)
            uid[j] <= 14'h3FFF;
        cnt <= 8'(DONE_LAT);
      end
      if (MEM_PROG)
      begin
        // flash and id programming only clears bits; eeprom is overwritten one byte at a time
        if (!MEM_SPACE)
          flash[MEM_ADDR[10:0]] <= flash[MEM_ADDR[10:0]] & MEM_WDATA;
        else if (MEM_ADDR <= 15'h0003)
          uid[MEM_ADDR[1:0]] <= uid[MEM_ADDR[1:0]] & MEM_WDATA;
        else if (MEM_ADDR[14:8] == 7'h70)
          ee[MEM_ADDR[7:0]] <= MEM_WDATA[7:0];
        prog_count <= prog_count + 1;
        cnt <= 8'(DONE_LAT);
      end
    end
  end
endmodule // nvmac_mem_model

// *** test/tb_nvm_access_controller.sv ***
`timescale 1ns/1ps
module tb_nvm_access_controller;
  logic        CLK, NRST, WR, RD, IND_REQ, IND_WE, CODE_PROT, IND_VALID, CPU_STALL;
  logic        MEM_SPACE, MEM_RD, MEM_ERASE, MEM_PROG, MEM_DONE;
  logic [2:0]  ADDR;
  logic [7:0]  WDATA, RDATA;
  logic [15:0] IND_ADDR;
  logic [13:0] IND_RDATA, MEM_RDATA, MEM_WDATA;
  logic [14:0] MEM_ADDR;
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  nvm_access_controller u_nvm_access_controller (
    .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .IND_REQ(IND_REQ), .IND_WE(IND_WE), .IND_ADDR(IND_ADDR), .IND_RDATA(IND_RDATA),
    .IND_VALID(IND_VALID), .CODE_PROT(CODE_PROT), .CPU_STALL(CPU_STALL), .MEM_ADDR(MEM_ADDR),
    .MEM_SPACE(MEM_SPACE), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .MEM_ERASE(MEM_ERASE),
    .MEM_PROG(MEM_PROG), .MEM_WDATA(MEM_WDATA), .MEM_DONE(MEM_DONE));
  nvmac_mem_model #(.DONE_LAT(4)) u_nvmac_mem_model (
    .CLK(CLK), .NRST(NRST), .MEM_ADDR(MEM_ADDR), .MEM_SPACE(MEM_SPACE), .MEM_RD(MEM_RD),
    .MEM_RDATA(MEM_RDATA), .MEM_ERASE(MEM_ERASE), .MEM_PROG(MEM_PROG), .MEM_WDATA(MEM_WDATA),
    .MEM_DONE(MEM_DONE));
  always #12.5 CLK = ~CLK;
  function automatic logic [13:0] fp(input logic [14:0] a);
    return a[13:0] ^ 14'h1555;
  endfunction
  function automatic int pc();
    return u_nvmac_mem_model.prog_count;
  endfunction
  task automatic test_done();
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    RD <= 1'b0;
    WR <= 1'b1;
  endtask
  task automatic idle();
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic set_ad(input logic [14:0] a, input logic [13:0] d);
    wr(3'h2, a[7:0]);
    wr(3'h3, {1'b0, a[14:8]});
    wr(3'h4, d[7:0]);
    wr(3'h5, {2'b00, d[13:8]});
  endtask
  task automatic unlock(input logic [7:0] c);
    wr(3'h1, 8'h55);
    wr(3'h1, 8'hAA);
    wr(3'h0, c);
    idle();
  endtask
  task automatic wait_done();
    logic [7:0] v;
    int         n;
    n = 0;
    v = 8'hFF;
    while (v[1] !== 1'b0 && n < 200)
    begin
      rd(3'h0, v);
      n++;
    end
    check(16'(v[1]), 16'h0000);
    check(16'(v[7]), 16'h0001);
    wr(3'h0, 8'h00);
    idle();
  endtask
  task automatic rd_word(input logic [7:0] c, input logic [14:0] a, input logic [13:0] e);
    logic [7:0] v;
    set_ad(a, 14'h0000);
    wr(3'h0, c);
    idle();
    #1 check(16'(CPU_STALL), 16'h0001);
    rd(3'h4, v);
    check(16'(v), 16'(e[7:0]));
    rd(3'h5, v);
    check(16'(v), 16'(e[13:8]));
    rd(3'h0, v);
    check(16'(v[0]), 16'h0000);
  endtask
  task automatic t_read();
    logic [7:0] v;
    rd_word(8'h01, 15'h0123, fp(15'h0123));
    rd_word(8'h41, 15'h0002, 14'h0A02);
    rd_word(8'h41, 15'h7003, {6'h00, 8'h03 ^ 8'h3C});
    wr(3'h2, 8'h99);
    idle();
    rd(3'h4, v);
    check(16'(v), 16'(8'h03 ^ 8'h3C));
  endtask
  task automatic t_ind();
    int p;
    p = pc();
    @(posedge CLK);
    IND_ADDR <= 16'h8456;
    IND_REQ <= 1'b1;
    #1 check(16'(CPU_STALL), 16'h0001);
    @(posedge CLK);
    IND_ADDR <= 16'h0011;
    #1 check(16'(IND_VALID), 16'h0001);
    check(16'(IND_RDATA), 16'(fp(15'h0456)));
    @(posedge CLK);
    IND_WE <= 1'b1;
    IND_ADDR <= 16'h8010;
    #1 check(16'(IND_RDATA), 16'(8'h11 ^ 8'h3C));
    @(posedge CLK);
    IND_REQ <= 1'b0;
    IND_WE <= 1'b0;
    #1 check(16'(IND_VALID), 16'h0000);
    check(16'(pc() - p), 16'h0000);
  endtask
  task automatic t_ee();
    int p;
    p = pc();
    set_ad(15'h7005, 14'h005A);
    unlock(8'h46);
    #1 check(16'(MEM_PROG), 16'h0001);
    wait_done();
    check(16'(u_nvmac_mem_model.ee[5]), 16'h005A);
    check(16'(u_nvmac_mem_model.ee[6]), 16'(8'h06 ^ 8'h3C));
    check(16'(pc() - p), 16'h0001);
  endtask
  task automatic t_bad();
    logic [7:0] v;
    int         p;
    for (int k = 0; k < 6; k++)
    begin
      p = pc();
      set_ad(k == 3 ? 15'h0005 : (k == 4 ? 15'h0800 : 15'h7006), 14'h0033);
      case (k)
        0:
        begin
          wr(3'h1, 8'h56);
          wr(3'h1, 8'hAA);
        end
        1:
        begin
          wr(3'h1, 8'hAA);
          wr(3'h1, 8'h55);
        end
        2:
        begin
          wr(3'h1, 8'h55);
          rd(3'h1, v);
          wr(3'h1, 8'hAA);
        end
        5:
        begin
          wr(3'h1, 8'h55);
          wr(3'h0, 8'h46);
          wr(3'h1, 8'hAA);
        end
        default:
        begin
          wr(3'h1, 8'h55);
          wr(3'h1, 8'hAA);
        end
      endcase
      wr(3'h0, k == 4 ? 8'h06 : 8'h46);
      idle();
      repeat (8) @(posedge CLK);
      rd(3'h0, v);
      check(16'(v[1]), 16'h0000);
      check(16'(pc() - p), 16'h0000);
    end
  endtask
  task automatic t_prot();
    logic [7:0] v;
    int         p;
    @(posedge CLK);
    CODE_PROT <= 1'b1;
    set_ad(15'h0123, 14'h0011);
    wr(3'h0, 8'h01);
    idle();
    rd(3'h4, v);
    check(16'(v), 16'h0011);
    p = pc();
    set_ad(15'h7007, 14'h0022);
    unlock(8'h46);
    repeat (8) @(posedge CLK);
    check(16'(pc() - p), 16'h0000);
    rd(3'h0, v);
    check(16'(v[1:0]), 16'h0000);
    @(posedge CLK);
    CODE_PROT <= 1'b0;
  endtask
  task automatic t_row();
    logic [7:0] v;
    int         p;
    set_ad(15'h0047, 14'h0000);
    unlock(8'h0E);
    #1 check(16'(CPU_STALL), 16'h0001);
    check(16'(MEM_ADDR), 16'h0040);
    wait_done();
    for (int i = 32'h40; i < 32'h60; i++)
      check(16'(u_nvmac_mem_model.flash[i]), 16'h3FFF);
    check(16'(u_nvmac_mem_model.flash[32'h60]), 16'(fp(15'h0060)));
    set_ad(15'h0041, 14'h2A5C);
    unlock(8'h16);
    set_ad(15'h005F, 14'h0F0F);
    unlock(8'h16);
    rd(3'h0, v);
    check(16'(v[1]), 16'h0000);
    p = pc();
    set_ad(15'h0042, 14'h1111);
    unlock(8'h06);
    #1 check(16'(CPU_STALL), 16'h0001);
    wait_done();
    check(16'(pc() - p), 16'h0003);
    check(16'(u_nvmac_mem_model.flash[32'h41]), 16'h2A5C);
    check(16'(u_nvmac_mem_model.flash[32'h5F]), 16'h0F0F);
    check(16'(u_nvmac_mem_model.flash[32'h42]), 16'h1111);
    check(16'(u_nvmac_mem_model.flash[32'h40]), 16'h3FFF);
  endtask
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    CLK = 1'b0;
    NRST = 1'b0;
    ADDR = 3'h0;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    IND_REQ = 1'b0;
    IND_WE = 1'b0;
    IND_ADDR = 16'h0000;
    CODE_PROT = 1'b0;
    repeat (6) @(posedge CLK);
    NRST <= 1'b1;
    t_read();
    t_ind();
    t_ee();
    t_bad();
    t_prot();
    t_row();
    test_done();
  end
endmodule // tb_nvm_access_controller
